// ---- src/bir_board_info.sv ----
// Purpose: Board information register bank with APB slave access.
// Assumes: One 250 MHz clock, synchronous active-high reset, APB master.
// Notes:   Optional inputs exist as ports; disabled size and revision inputs read as build-time values, others as zero.
`timescale 1ns/1ps

// Overview of operation
// - A 16-bit board type constant is fixed at build time.
// - Code type identity is board type above a 4-bit code nibble.
// - Logic size string accepted; only seven listed values are valid.
// - Logic size input is used only when its option is set.
// - Front panel 4-bit identity is taken when enabled; card drives it.
// - A 32-bit build-time user word is readable as status.
// - Combined interrupt output is the OR of present requests, if enabled.
// - Each of twelve request inputs exists only with its own option.
// - Code revision number is an 8-bit value, zero to 255.
// - Revision date holds month 1-12, day 1-31, year 0-99.
// - Revision information input is used only when its option is set.
// - User and monitor LED drives exist only with their own options.
// - Host link status input is reported only when enabled.
// - Reset returns every control register to its initial value.
module bir_board_info #(
  parameter logic [15:0] board_type_ident = 16'h0000,
  parameter logic [3:0] code_nibble = 4'h0,
  parameter logic [23:0] logic_size = bir_pkg::SIZE_DEFAULT,
  parameter logic [31:0] user_word = 32'h00000000,
  parameter logic [7:0] code_revision = 8'h00,
  parameter logic [7:0] rev_month = 8'h01,
  parameter logic [7:0] rev_day = 8'h01,
  parameter logic [7:0] rev_year = 8'h00,
  parameter bit opt_size_in = 1'b0,
  parameter bit opt_panel_in = 1'b0,
  parameter bit opt_rev_info_in = 1'b0,
  parameter bit opt_user_led = 1'b0,
  parameter bit opt_sysmon_led = 1'b0,
  parameter bit opt_link_status = 1'b0,
  parameter bit opt_request_out = 1'b0,
  parameter bit opt_temp_request = 1'b0,
  parameter bit opt_sysmon_request = 1'b0,
  parameter bit opt_serial_bus_one_request = 1'b0,
  parameter bit opt_serial_bus_two_request = 1'b0,
  parameter bit opt_user_request_one = 1'b0,
  parameter bit opt_user_request_two = 1'b0,
  parameter bit opt_user_request_three = 1'b0,
  parameter bit opt_user_request_four = 1'b0,
  parameter bit opt_user_request_five = 1'b0,
  parameter bit opt_user_request_six = 1'b0,
  parameter bit opt_user_request_seven = 1'b0,
  parameter bit opt_user_request_eight = 1'b0
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [2:0] pprot,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [23:0] logic_size_in,
  input wire logic [3:0] panel_ident_in,
  input wire logic [31:0] rev_info_in,
  input wire logic [15:0] link_status_in,
  input wire logic [11:0] request_in,
  output logic [3:0] byte_swap_ctrl,
  output logic user_led_drive,
  output logic sysmon_led_drive,
  output logic request_out
);

  // ----------------------------------------------------------------
  // Build-time identity values
  // ----------------------------------------------------------------
  // Board type placed in the top bits, code nibble below
  localparam logic [bir_pkg::CODE_TYPE_W-1:0] logic_code_type_ident =
    {board_type_ident, code_nibble};

  // Date checked once at elaboration; a bad date is flagged, not hidden
  // Raw fields still read back, so a mistyped date stays traceable
  localparam bit date_ok =
    (rev_month >= bir_pkg::MONTH_MIN) &&
    (rev_month <= bir_pkg::MONTH_MAX) &&
    (rev_day >= bir_pkg::DAY_MIN) &&
    (rev_day <= bir_pkg::DAY_MAX) &&
    (rev_year <= bir_pkg::YEAR_MAX);

  // Per-request presence, index order matches the request_in vector
  localparam bit [bir_pkg::REQ_N-1:0] req_present = {
    opt_user_request_eight,
    opt_user_request_seven,
    opt_user_request_six,
    opt_user_request_five,
    opt_user_request_four,
    opt_user_request_three,
    opt_user_request_two,
    opt_user_request_one,
    opt_serial_bus_two_request,
    opt_serial_bus_one_request,
    opt_sysmon_request,
    opt_temp_request
  };

  // ----------------------------------------------------------------
  // Optional inputs
  // ----------------------------------------------------------------
  logic [23:0] size_in_q;
  logic [3:0] panel_q;
  logic [31:0] rev_in_q;
  logic [15:0] link_q;
  logic [11:0] req_q;

  // One flop per optional input: reads see a settled value,
  // at the cost of one cycle between a pin change and its status bit
  // Size input only sampled when the option exists
  bir_opt_gate #(.present(opt_size_in), .width(bir_pkg::SIZE_W)) u_size_gate (
    .clock(clock),
    .srst(srst),
    .din(logic_size_in),
    .dout(size_in_q)
  );

  // Panel card drives its identity; absent panel reads zero
  bir_opt_gate #(.present(opt_panel_in), .width(bir_pkg::PANEL_W)) u_panel_gate (
    .clock(clock),
    .srst(srst),
    .din(panel_ident_in),
    .dout(panel_q)
  );

  // Revision information replaces the built-in values when present
  bir_opt_gate #(.present(opt_rev_info_in), .width(bir_pkg::DATA_W)) u_rev_gate (
    .clock(clock),
    .srst(srst),
    .din(rev_info_in),
    .dout(rev_in_q)
  );

  // Host link status for reporting only
  bir_opt_gate #(.present(opt_link_status), .width(bir_pkg::LINK_W)) u_link_gate (
    .clock(clock),
    .srst(srst),
    .din(link_status_in),
    .dout(link_q)
  );

  // One gate per request line; disabled lines are held at zero
  for (genvar gi = 0; gi < bir_pkg::REQ_N; gi++) begin : g_req
    bir_opt_gate #(.present(req_present[gi]), .width(1)) u_req_gate (
      .clock(clock),
      .srst(srst),
      .din(request_in[gi]),
      .dout(req_q[gi])
    );
  end

  // ----------------------------------------------------------------
  // Logic size selection and check
  // ----------------------------------------------------------------
  logic [23:0] size_eff;
  logic size_ok;

  // A wrong size is reported through the valid bit, never corrected
  // Input wins over the parameter only when the input exists
  always_comb begin
    size_eff = opt_size_in ? size_in_q : logic_size;
    size_ok = 1'b0;
    for (int i = 0; i < bir_pkg::SIZE_N; i++) begin
      if (size_eff == bir_pkg::SIZE_LIST[i]) begin
        size_ok = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic access;
  logic addr_hit;
  logic wr_fire;
  logic [31:0] rd_word;

  // Protection bits are ignored; every access is treated alike
  // Access phase; one wait state before pready so reads are registered
  assign access = psel & penable;
  // Write lands on the same edge that samples pready high
  assign wr_fire = access & pready & pwrite & addr_hit;

  // Only aligned words inside the map are answered without error
  always_comb begin
    addr_hit = 1'b0;
    if (paddr[1:0] == bir_pkg::WORD_ALIGN) begin
      case (paddr)
        bir_pkg::OFF_SWAP,
        bir_pkg::OFF_CODE_TYPE,
        bir_pkg::OFF_SIZE,
        bir_pkg::OFF_USER,
        bir_pkg::OFF_REV,
        bir_pkg::OFF_PANEL_LINK,
        bir_pkg::OFF_LED,
        bir_pkg::OFF_REQ_STAT: begin
          addr_hit = 1'b1;
        end
        default: begin
          addr_hit = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  // Decode uses paddr only; prdata takes a copy on the edge that raises pready
  // Unused bits read as zero
  always_comb begin
    rd_word = '0;
    case (paddr)
      bir_pkg::OFF_SWAP: begin
        rd_word[bir_pkg::SWAP_W-1:0] = byte_swap_ctrl;
      end
      bir_pkg::OFF_CODE_TYPE: begin
        rd_word[bir_pkg::CODE_TYPE_W-1:0] = logic_code_type_ident;
      end
      bir_pkg::OFF_SIZE: begin
        rd_word[bir_pkg::SIZE_W-1:0] = size_eff;
        rd_word[bir_pkg::SIZE_VALID_BIT] = size_ok;
        rd_word[bir_pkg::DATE_VALID_BIT] = date_ok;
      end
      bir_pkg::OFF_USER: begin
        rd_word = user_word;
      end
      bir_pkg::OFF_REV: begin
        if (opt_rev_info_in) begin
          rd_word = rev_in_q;
        end else begin
          rd_word[bir_pkg::REV_NUM_LSB +: bir_pkg::REV_FIELD_W] = code_revision;
          rd_word[bir_pkg::REV_MONTH_LSB +: bir_pkg::REV_FIELD_W] = rev_month;
          rd_word[bir_pkg::REV_DAY_LSB +: bir_pkg::REV_FIELD_W] = rev_day;
          rd_word[bir_pkg::REV_YEAR_LSB +: bir_pkg::REV_FIELD_W] = rev_year;
        end
      end
      bir_pkg::OFF_PANEL_LINK: begin
        rd_word[bir_pkg::PANEL_LSB +: bir_pkg::PANEL_W] = panel_q;
        rd_word[bir_pkg::PANEL_PRESENT_BIT] = opt_panel_in;
        rd_word[bir_pkg::LINK_PRESENT_BIT] = opt_link_status;
        rd_word[bir_pkg::LINK_LSB +: bir_pkg::LINK_W] = link_q;
      end
      bir_pkg::OFF_LED: begin
        rd_word[bir_pkg::LED_USER_BIT] = user_led_drive;
        rd_word[bir_pkg::LED_SYSMON_BIT] = sysmon_led_drive;
      end
      bir_pkg::OFF_REQ_STAT: begin
        rd_word[bir_pkg::REQ_N-1:0] = req_q;
        rd_word[bir_pkg::REQ_OUT_BIT] = request_out;
        rd_word[bir_pkg::REQ_PRESENT_LSB +: bir_pkg::REQ_N] = req_present;
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // APB response
  // ----------------------------------------------------------------
  // Ready pulses for one cycle, second cycle of the access phase
  // Costs a wait state per transfer but keeps decode off the bus path
  always_ff @(posedge clock) begin
    if (srst) begin
      pready <= 1'b0;
    end else begin
      pready <= access & ~pready;
    end
  end

  // Error flag travels with ready so the master sees both together
  always_ff @(posedge clock) begin
    if (srst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= access & ~pready & ~addr_hit;
    end
  end

  // Read data captured on the same edge that raises ready; zero on errors
  always_ff @(posedge clock) begin
    if (srst) begin
      prdata <= '0;
    end else if (access & ~pready) begin
      prdata <= (~pwrite & addr_hit) ? rd_word : '0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Writable bits all sit in byte lane zero; upper strobes are ignored
  // Byte swap control, low byte lane only
  always_ff @(posedge clock) begin
    if (srst) begin
      byte_swap_ctrl <= bir_pkg::SWAP_RST;
    end else if (wr_fire && (paddr == bir_pkg::OFF_SWAP) && pstrb[0]) begin
      byte_swap_ctrl <= pwdata[bir_pkg::SWAP_W-1:0];
    end
  end

  // User LED; a disabled drive stays dark whatever software writes
  always_ff @(posedge clock) begin
    if (srst) begin
      user_led_drive <= bir_pkg::LED_RST;
    end else if (wr_fire && (paddr == bir_pkg::OFF_LED) && pstrb[0]) begin
      user_led_drive <= opt_user_led & pwdata[bir_pkg::LED_USER_BIT];
    end
  end

  // Monitor LED, controlled apart from the user LED
  always_ff @(posedge clock) begin
    if (srst) begin
      sysmon_led_drive <= bir_pkg::LED_RST;
    end else if (wr_fire && (paddr == bir_pkg::OFF_LED) && pstrb[0]) begin
      sysmon_led_drive <= opt_sysmon_led & pwdata[bir_pkg::LED_SYSMON_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Combined interrupt request
  // ----------------------------------------------------------------
  // Plain OR, no latching: the sources keep their own flags
  // One more cycle of latency, but the output can never glitch
  always_ff @(posedge clock) begin
    if (srst) begin
      request_out <= 1'b0;
    end else begin
      request_out <= opt_request_out & (|(req_q & req_present));
    end
  end

endmodule

// ---- src/bir_pkg.sv ----
// Purpose: Shared constants for the board information register bank.
// Assumes: APB slave with a 6-bit byte address and 32-bit data words.
// Notes:   Every offset, field position and control register reset value lives here.
package bir_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam logic [1:0] WORD_ALIGN = 2'h0;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_SWAP = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_CODE_TYPE = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_SIZE = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_USER = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_REV = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_PANEL_LINK = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_LED = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_REQ_STAT = 6'h1C;

  // ----------------------------------------------------------------
  // Identity and revision field widths and positions
  // ----------------------------------------------------------------
  localparam int BOARD_W = 16;
  localparam int CODE_NIB_W = 4;
  localparam int CODE_TYPE_W = BOARD_W + CODE_NIB_W;
  localparam int REV_FIELD_W = 8;
  localparam int REV_NUM_LSB = 24;
  localparam int REV_MONTH_LSB = 16;
  localparam int REV_DAY_LSB = 8;
  localparam int REV_YEAR_LSB = 0;
  localparam logic [7:0] MONTH_MIN = 8'h01;
  localparam logic [7:0] MONTH_MAX = 8'h0C;
  localparam logic [7:0] DAY_MIN = 8'h01;
  localparam logic [7:0] DAY_MAX = 8'h1F;
  localparam logic [7:0] YEAR_MAX = 8'h63;

  // ----------------------------------------------------------------
  // Logic size string: three ASCII characters, seven permitted values
  // ----------------------------------------------------------------
  localparam int SIZE_W = 24;
  localparam int SIZE_VALID_BIT = 31;
  localparam int DATE_VALID_BIT = 30;
  localparam int SIZE_N = 7;
  localparam logic [SIZE_W-1:0] SIZE_LIST [SIZE_N] = '{
    24'h303235, 24'h303335, 24'h303430, 24'h303630,
    24'h303835, 24'h303935, 24'h313135
  };
  localparam logic [SIZE_W-1:0] SIZE_DEFAULT = 24'h303630;

  // ----------------------------------------------------------------
  // Panel / link status word
  // ----------------------------------------------------------------
  localparam int PANEL_W = 4;
  localparam int PANEL_LSB = 0;
  localparam int PANEL_PRESENT_BIT = 4;
  localparam int LINK_PRESENT_BIT = 5;
  localparam int LINK_W = 16;
  localparam int LINK_LSB = 16;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  localparam int SWAP_W = 4;
  localparam logic [SWAP_W-1:0] SWAP_RST = 4'h0;
  localparam int LED_USER_BIT = 0;
  localparam int LED_SYSMON_BIT = 1;
  localparam logic LED_RST = 1'b0;

  // ----------------------------------------------------------------
  // Interrupt request inputs, index order
  // ----------------------------------------------------------------
  localparam int REQ_TEMP = 0;
  localparam int REQ_SYSMON = 1;
  localparam int REQ_BUS_ONE = 2;
  localparam int REQ_BUS_TWO = 3;
  localparam int REQ_USER_FIRST = 4;
  localparam int REQ_N = 12;
  localparam int REQ_OUT_BIT = 16;
  localparam int REQ_PRESENT_LSB = 20;

endpackage

// ---- src/bir_opt_gate.sv ----
// Purpose: Registers one optional input, or holds it at zero when absent.
// Assumes: Input is synchronous to clock.
// Notes:   An absent input can never leak into the bank's state.
`timescale 1ns/1ps
module bir_opt_gate #(
  parameter bit present = 1'b0,
  parameter int width = 1
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [width-1:0] din,
  output logic [width-1:0] dout
);

  // ----------------------------------------------------------------
  // Capture stage
  // ----------------------------------------------------------------
  // Absent option reads as a constant zero
  always_ff @(posedge clock) begin
    if (srst) begin
      dout <= '0;
    end else if (present) begin
      dout <= din;
    end else begin
      dout <= '0;
    end
  end

endmodule

// ---- tb/bir_board_info_asserts.sv ----
// Purpose: Port-level checks for the board information bank.
// Assumes: The APB master holds each request until pready.
// Notes:   Bound into every instance of the bank.
`timescale 1ns/1ps
module bir_board_info_asserts #(
  parameter bit opt_request_out = 1'b0,
  parameter bit opt_user_led = 1'b0,
  parameter bit opt_sysmon_led = 1'b0,
  parameter logic [11:0] req_mask = 12'h000
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [11:0] request_in,
  input wire logic [3:0] byte_swap_ctrl,
  input wire logic user_led_drive,
  input wire logic sysmon_led_drive,
  input wire logic request_out
);
  logic rst_q;
  logic [1:0] age_q;
  logic bad_addr;
  logic wr_ok;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Age since reset, so two-deep history is never taken from reset time
  always_ff @(posedge clock) begin
    rst_q <= srst;
    if (srst) begin
      age_q <= 2'h0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end
  // Decode of the accepted cycle
  assign bad_addr = (paddr[1:0] != 2'h0) || (paddr > bir_pkg::OFF_REQ_STAT);
  assign wr_ok = pready && pwrite && !bad_addr && pstrb[0];
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence access_start;
    psel && penable && !pready;
  endsequence
  sequence one_wait;
    ##1 (pready && psel && penable) ##1 !pready;
  endsequence
  a_ready_one_wait: assert property (access_start |-> one_wait)
    else $error("pready not after exactly one wait state");
  a_err_decode: assert property (pready |-> (pslverr == bad_addr))
    else $error("pslverr does not match address decode");
  a_err_qualified: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_reset_clear: assert property (rst_q |-> !pready && !request_out &&
    byte_swap_ctrl == 4'h0 && !user_led_drive && !sysmon_led_drive)
    else $error("control outputs not cleared by reset");
  a_swap_write: assert property (wr_ok && paddr == bir_pkg::OFF_SWAP |=>
    byte_swap_ctrl == $past(pwdata[3:0]))
    else $error("swap control missed a write");
  a_swap_hold: assert property (!(wr_ok && paddr == bir_pkg::OFF_SWAP) |=>
    $stable(byte_swap_ctrl))
    else $error("swap control changed without a write");
  a_led_write: assert property (wr_ok && paddr == bir_pkg::OFF_LED |=>
    user_led_drive == (opt_user_led && $past(pwdata[0])))
    else $error("user led missed a write");
  a_led_hold: assert property (!(wr_ok && paddr == bir_pkg::OFF_LED) |=>
    $stable(user_led_drive) && $stable(sysmon_led_drive))
    else $error("led drive changed without a write");
  a_sysmon_absent: assert property (!opt_sysmon_led |-> !sysmon_led_drive)
    else $error("absent monitor led driven");
  a_req_combine: assert property (age_q == 2'h3 |-> request_out ==
    (opt_request_out && |($past(request_in, 2) & req_mask)))
    else $error("combined request wrong");
endmodule

bind bir_board_info bir_board_info_asserts #(
  .opt_request_out(opt_request_out), .opt_user_led(opt_user_led),
  .opt_sysmon_led(opt_sysmon_led),
  .req_mask({opt_user_request_eight, opt_user_request_seven, opt_user_request_six,
    opt_user_request_five, opt_user_request_four, opt_user_request_three,
    opt_user_request_two, opt_user_request_one, opt_serial_bus_two_request,
    opt_serial_bus_one_request, opt_sysmon_request, opt_temp_request})
) u_chk (
  .clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .request_in(request_in), .byte_swap_ctrl(byte_swap_ctrl),
  .user_led_drive(user_led_drive), .sysmon_led_drive(sysmon_led_drive),
  .request_out(request_out)
);

// ---- tb/bir_apb_host.sv ----
// Purpose: APB host model that runs one transfer per request.
// Assumes: Requests arrive only after reset has been released.
// Notes:   Released address and data are inverted so stale values never match.
`timescale 1ns/1ps
module bir_apb_host (
  input wire logic clock,
  input wire logic srst,
  input wire logic req,
  input wire logic req_wr,
  input wire logic [5:0] req_addr,
  input wire logic [31:0] req_wdata,
  output logic done,
  output logic [31:0] rdata,
  output logic err,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [5:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  // Setup, then access held until pready is seen high; idle in reset
  always @(posedge clock) begin
    if (srst) begin
      {done, err, psel, penable, pwrite} <= 5'h00;
      {paddr, pwdata, rdata} <= 70'h0;
    end else begin
      done <= 1'b0;
      if (psel && penable && pready) begin
        rdata <= prdata;
        err <= pslverr;
        done <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~paddr;
        pwdata <= ~pwdata;
      end else if (psel) begin
        penable <= 1'b1;
      end else if (req && !done) begin
        psel <= 1'b1;
        pwrite <= req_wr;
        paddr <= req_addr;
        pwdata <= req_wdata;
      end
    end
  end
endmodule

// ---- tb/bir_board_info_tb.sv ----
// Purpose: Self-checking bench for the board information bank.
// Assumes: One 250 MHz clock and an APB host model.
// Notes:   Options are mixed on and off so absent inputs are exercised.
`timescale 1ns/1ps
module bir_board_info_tb;
  localparam logic [11:0] MASK = 12'hD55;
  localparam logic [15:0] BRD = 16'hA5C3;
  localparam logic [3:0] NIB = 4'h7;
  localparam logic [31:0] UW = 32'hC001D00D;
  localparam logic [31:0] REVW = 32'hFF0C1F63;
  localparam bit ON = 1'b1;
  logic clock = 0, srst = 1, req = 0, req_wr = 0, done, err, psel, penable, pwrite;
  logic pready, pslverr, user_led_drive, sysmon_led_drive, request_out;
  logic [5:0] req_addr = 0, paddr;
  logic [31:0] req_wdata = 0, rdata, pwdata, prdata, rev_info_in = 32'h12345678;
  logic [23:0] logic_size_in = "060";
  logic [3:0] panel_ident_in = 4'hB, byte_swap_ctrl, strb = 4'hF;
  logic [15:0] link_status_in = 16'h5A3C;
  logic [11:0] request_in = 0;
  logic [23:0] sz [7] = '{"025", "035", "040", "060", "085", "095", "115"};
  int err_total = 0, tests_run = 0;
  always #2 clock = ~clock;
  bir_apb_host u_host (.clock(clock), .srst(srst), .req(req), .req_wr(req_wr),
    .req_addr(req_addr), .req_wdata(req_wdata), .done(done), .rdata(rdata), .err(err),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));
  bir_board_info #(.board_type_ident(BRD), .code_nibble(NIB), .user_word(UW),
    .code_revision(REVW[31:24]), .rev_month(REVW[23:16]), .rev_day(REVW[15:8]),
    .rev_year(REVW[7:0]), .opt_size_in(ON), .opt_panel_in(ON), .opt_user_led(ON),
    .opt_link_status(ON), .opt_request_out(ON), .opt_temp_request(MASK[0]),
    .opt_serial_bus_one_request(MASK[2]), .opt_user_request_one(MASK[4]),
    .opt_user_request_three(MASK[6]), .opt_user_request_five(MASK[8]),
    .opt_user_request_seven(MASK[10]), .opt_user_request_eight(MASK[11])
  ) u_dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pprot(3'h0), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .logic_size_in(logic_size_in),
    .panel_ident_in(panel_ident_in), .rev_info_in(rev_info_in),
    .link_status_in(link_status_in), .request_in(request_in),
    .byte_swap_ctrl(byte_swap_ctrl), .user_led_drive(user_led_drive),
    .sysmon_led_drive(sysmon_led_drive), .request_out(request_out));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask
  // One transfer through the host model, bounded wait for its answer
  task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d,
      input logic e_exp, input logic [31:0] q_exp, input string name);
    int n;
    n = 0;
    @(posedge clock);
    req <= 1'b1;
    req_wr <= w;
    req_addr <= a;
    req_wdata <= d;
    do begin
      @(negedge clock);
      n++;
    end while (done !== 1'b1 && n < 40);
    chk({name, " done"}, 1, done);
    chk({name, " err"}, e_exp, err);
    if (!w) chk(name, q_exp, rdata);
    @(posedge clock);
    req <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_identity;
    bus(bir_pkg::OFF_CODE_TYPE, 0, 0, 0, {12'h000, BRD, NIB}, "code");
    bus(bir_pkg::OFF_USER, 0, 0, 0, UW, "user word");
    bus(bir_pkg::OFF_REV, 0, 0, 0, REVW, "revision");
    bus(bir_pkg::OFF_PANEL_LINK, 0, 0, 0, {16'h5A3C, 12'h003, 4'hB}, "panel");
  endtask
  task automatic t_size;
    for (int i = 0; i < 7; i++) begin
      logic_size_in <= sz[i];
      bus(bir_pkg::OFF_SIZE, 0, 0, 0, {2'h3, 6'h00, sz[i]}, "size");
    end
    logic_size_in <= "010";
    bus(bir_pkg::OFF_SIZE, 0, 0, 0, {2'h1, 6'h00, 24'h303130}, "bad size");
  endtask
  task automatic t_ctrl_reset;
    bus(bir_pkg::OFF_SWAP, 1, 32'h0000000F, 0, 0, "swap wr");
    bus(bir_pkg::OFF_SWAP, 0, 0, 0, 32'h0000000F, "swap rd");
    bus(bir_pkg::OFF_LED, 1, 32'h00000003, 0, 0, "led wr");
    chk("leds", 2'h1, {sysmon_led_drive, user_led_drive});
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(negedge clock);
    chk("reset ctrl", 5'h00, {byte_swap_ctrl, user_led_drive});
    bus(bir_pkg::OFF_SWAP, 0, 0, 0, 0, "swap after reset");
  endtask
  task automatic t_refused;
    bus(6'h20, 0, 0, 1, 0, "unmapped rd");
    bus(6'h02, 1, 32'h0000000F, 1, 0, "misaligned wr");
    strb <= 4'hE;
    bus(bir_pkg::OFF_SWAP, 1, 32'h0000000F, 0, 0, "no strobe wr");
    strb <= 4'hF;
    bus(bir_pkg::OFF_SWAP, 0, 0, 0, 0, "swap kept");
    bus(bir_pkg::OFF_USER, 1, 0, 0, 0, "ro wr");
    bus(bir_pkg::OFF_USER, 0, 0, 0, UW, "user kept");
  endtask
  task automatic t_requests;
    logic [11:0] r;
    for (int i = 0; i < 12; i++) begin
      r = 12'h001 << i;
      @(posedge clock);
      request_in <= r;
      repeat (3) @(posedge clock);
      @(negedge clock);
      chk("request_out", MASK[i], request_out);
      bus(bir_pkg::OFF_REQ_STAT, 0, 0, 0, {MASK, 3'h0, MASK[i], 4'h0, r & MASK}, "req");
    end
    request_in <= 12'h000;
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk("request idle", 0, request_out);
  endtask
  // ----------------------------------------------------------------
  // Verdict and sequencing
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the scenarios take
  initial begin
    #40000;
    err_total++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    t_identity();
    t_size();
    t_ctrl_reset();
    t_refused();
    t_requests();
    complete_run();
  end
endmodule
